// ==== pkg/bbf_pkg.sv ====
package bbf_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_LANE_LSB = 4;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_BYPASS = 3;
    localparam int STAT_SUSP = 4;
    localparam int ADDR_W = 21;
    localparam logic [3:0] LANES_RST = 4'hf;

    // ==========================================================
    // Device command words, replicated on every selected lane
    localparam logic [20:0] CMD_ADDR1 = 21'h000555;
    localparam logic [20:0] CMD_ADDR2 = 21'h0002aa;
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_PROG = 8'ha0;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_BYP_ENTER = 8'h20;
    localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
    localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;

    // ==========================================================
    // Timing, least times rounded up to whole 5 ns cycles
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_SETUP_NS = 10;
    localparam int T_WP_NS = 35;
    localparam int T_ACC_NS = 120;
    localparam int T_HOLD_NS = 20;
    localparam int T_RP_NS = 500;
    localparam int T_RH_NS = 50;
    localparam int SYNC_LAG = 2;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Types
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_WRITE = 4'h1,
        OP_PROG = 4'h2,
        OP_ERASE_SEC = 4'h3,
        OP_ERASE_ALL = 4'h4,
        OP_SUSPEND = 4'h5,
        OP_RESUME = 4'h6,
        OP_BYP_ENTER = 4'h7,
        OP_BYP_EXIT = 4'h8,
        OP_HW_RESET = 4'h9
    } bbf_op_t;

    typedef struct packed {
        logic [3:0] cs_n;
        logic [3:0] we_n;
        logic oe_n;
    } bbf_ctl_t;

    typedef struct packed {
        logic wr;
        logic [20:0] addr;
        logic [31:0] data;
        logic [3:0] lanes;
    } bbf_req_t;

    localparam bbf_ctl_t CTL_IDLE = '{cs_n: 4'hf, we_n: 4'hf, oe_n: 1'b1};
endpackage : bbf_pkg

// ==== rtl/bbf_cycle.sv ====
`timescale 1ns/10ps
`default_nettype none
module bbf_cycle
    import bbf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Request
    input wire logic start,
    input wire bbf_req_t req,
    output logic done,
    output logic [31:0] rdata,
    // Device pins
    input wire logic [31:0] dq_in,
    output bbf_ctl_t ctl,
    output logic [20:0] addr,
    output logic [31:0] dq_out,
    output logic [3:0] dq_oe
);
    typedef enum logic [1:0] {
        C_IDLE = 2'b00,
        C_SETUP = 2'b01,
        C_STRB = 2'b11,
        C_HOLD = 2'b10
    } bbf_cst_t;

    bbf_cst_t st_q;
    logic [7:0] cnt_q;
    logic wr_q;
    logic [3:0] lanes_q;
    logic last;

    assign last = (cnt_q == 8'h00);

    // ==========================================================
    // Phase sequencing
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_q <= C_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            lanes_q <= 4'h0;
        end else begin
            unique case (st_q)
                C_IDLE: if (start) begin
                    st_q <= C_SETUP;
                    cnt_q <= 8'(SETUP_CYC - 1);
                    wr_q <= req.wr;
                    lanes_q <= req.lanes;
                end
                C_SETUP: if (last) begin
                    st_q <= C_STRB;
                    // Reads wait out the input synchroniser too
                    cnt_q <= wr_q ? 8'(WP_CYC - 1) : 8'(ACC_CYC + SYNC_LAG - 1);
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                C_STRB: if (last) begin
                    st_q <= C_HOLD;
                    cnt_q <= 8'(HOLD_CYC - 1);
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
                C_HOLD: if (last) begin
                    st_q <= C_IDLE;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            endcase
        end
    end

    // ==========================================================
    // Pin drive
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctl <= CTL_IDLE;
            addr <= '0;
            dq_out <= '0;
            dq_oe <= 4'h0;
        end else if (st_q == C_IDLE && start) begin
            ctl.cs_n <= ~req.lanes;
            addr <= req.addr;
            dq_out <= req.data;
            dq_oe <= req.wr ? req.lanes : 4'h0;
        end else if (st_q == C_SETUP && last) begin
            if (wr_q) begin
                ctl.we_n <= ~lanes_q;
                ctl.oe_n <= 1'b1;
            end else begin
                ctl.we_n <= 4'hf;
                ctl.oe_n <= 1'b0;
            end
        end else if (st_q == C_STRB && last) begin
            ctl.we_n <= 4'hf;
            ctl.oe_n <= 1'b1;
        end else if (st_q == C_HOLD && last) begin
            ctl.cs_n <= 4'hf;
            dq_oe <= 4'h0;
        end
    end

    // ==========================================================
    // Completion and read capture
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            done <= 1'b0;
            rdata <= '0;
        end else begin
            done <= (st_q == C_HOLD) && last;
            if (st_q == C_STRB && last && !wr_q) begin
                rdata <= dq_in;
            end
        end
    end
endmodule : bbf_cycle
`default_nettype wire

// ==== rtl/bbf_host_ctrl.sv ====
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module bbf_host_ctrl
    import bbf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash device pins
    output bbf_ctl_t fl_ctl,
    output logic [20:0] fl_addr,
    input wire logic [31:0] fl_dq_in,
    output logic [31:0] fl_dq_out,
    output logic [3:0] fl_dq_oe,
    output logic fl_reset_n
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CMD = 3'b001,
        S_POLL = 3'b011,
        S_RST = 3'b010,
        S_REC = 3'b110
    } bbf_state_t;

    // ==========================================================
    // Command sequence tables
    function automatic logic [2:0] seq_len(bbf_op_t op, logic byp);
        unique case (op)
            OP_PROG: seq_len = byp ? 3'd2 : 3'd4;
            OP_ERASE_SEC, OP_ERASE_ALL: seq_len = 3'd6;
            OP_BYP_ENTER: seq_len = 3'd3;
            OP_BYP_EXIT: seq_len = 3'd2;
            default: seq_len = 3'd1;
        endcase
    endfunction : seq_len

    function automatic bbf_req_t cmd_step(bbf_op_t op, logic [2:0] st, logic byp,
                                          logic [20:0] a, logic [31:0] d,
                                          logic [3:0] ln);
        bbf_req_t r;
        logic [7:0] cb;
        logic raw;
        r.wr = 1'b1;
        r.lanes = ln;
        r.addr = st[0] ? CMD_ADDR2 : CMD_ADDR1;
        cb = st[0] ? CMD_UNLOCK2 : CMD_UNLOCK1;
        raw = 1'b0;
        unique case (op)
            OP_READ: begin
                r.wr = 1'b0;
                r.addr = a;
                raw = 1'b1;
            end
            OP_WRITE: begin
                r.addr = a;
                raw = 1'b1;
            end
            OP_PROG: begin
                if (st == (byp ? 3'd0 : 3'd2)) begin
                    r.addr = CMD_ADDR1;
                    cb = CMD_PROG;
                end else if (st == (byp ? 3'd1 : 3'd3)) begin
                    r.addr = a;
                    raw = 1'b1;
                end
            end
            OP_ERASE_SEC, OP_ERASE_ALL: begin
                if (st == 3'd2) begin
                    cb = CMD_ERASE;
                end else if (st == 3'd3 || st == 3'd4) begin
                    // Second unlock pair starts again on the first address
                    r.addr = st[0] ? CMD_ADDR1 : CMD_ADDR2;
                    cb = st[0] ? CMD_UNLOCK1 : CMD_UNLOCK2;
                end else if (st == 3'd5) begin
                    r.addr = (op == OP_ERASE_SEC) ? a : CMD_ADDR1;
                    cb = (op == OP_ERASE_SEC) ? CMD_SECTOR : CMD_CHIP;
                end
            end
            OP_SUSPEND: begin
                r.addr = a;
                cb = CMD_SUSPEND;
            end
            OP_RESUME: begin
                r.addr = a;
                cb = CMD_RESUME;
            end
            OP_BYP_ENTER: begin
                if (st == 3'd2) begin
                    cb = CMD_BYP_ENTER;
                end
            end
            OP_BYP_EXIT: begin
                r.addr = a;
                cb = st[0] ? CMD_BYP_EXIT2 : CMD_BYP_EXIT1;
            end
            default: begin
                r.addr = a;
            end
        endcase
        r.data = raw ? d : {4{cb}};
        return r;
    endfunction : cmd_step

    function automatic logic [3:0] toggle_bits(logic [31:0] d, logic [3:0] ln);
        return {d[30], d[22], d[14], d[6]} & ln;
    endfunction : toggle_bits

    // ==========================================================
    // Declarations
    bbf_state_t state_q;
    bbf_op_t op_q;
    bbf_op_t op_new;
    logic [20:0] addr_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic [3:0] lanes_q;
    logic [2:0] step_q;
    logic [7:0] rst_cnt_q;
    logic done_q;
    logic refused_q;
    logic byp_q;
    logic susp_q;
    logic pend_susp_q;
    logic have_prev_q;
    logic [3:0] prev_q;
    logic start_q;
    bbf_req_t req_q;
    logic cyc_done;
    logic [31:0] cyc_rdata;
    logic [31:0] dq_sync;
    logic wr_take;
    logic go;
    logic idle;
    logic erase_run;
    logic susp_ok;
    logic accept;
    logic refuse;
    logic finish;
    logic last_step;
    logic poll_match;

    assign op_new = bbf_op_t'(pwdata[CTRL_OP_LSB +: 4]);
    assign idle = (state_q == S_IDLE);
    assign wr_take = psel && penable && pwrite && pready;
    assign go = wr_take && (paddr == REG_CTRL);
    assign erase_run = (op_q == OP_ERASE_SEC) || (op_q == OP_ERASE_ALL) || (op_q == OP_RESUME);
    assign susp_ok = (state_q == S_POLL) && erase_run && !pend_susp_q;
    // Only suspend gets through, and only while an erase or a resume is being polled
    assign accept = go && (idle || (op_new == OP_SUSPEND && susp_ok));
    assign refuse = wr_take && !idle && !accept && (paddr != REG_STAT);
    assign last_step = (step_q + 3'd1 == seq_len(op_q, byp_q));
    assign poll_match = have_prev_q && (toggle_bits(cyc_rdata, lanes_q) == prev_q);
    assign finish = (state_q == S_CMD && cyc_done && last_step
                     && !(op_q inside {OP_PROG, OP_ERASE_SEC, OP_ERASE_ALL, OP_RESUME}))
                    || (state_q == S_POLL && cyc_done && !pend_susp_q && poll_match)
                    || (state_q == S_REC && rst_cnt_q == 8'h00);

    // ==========================================================
    // Instances
    bbf_sync #(.W(32)) u_dq_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in(fl_dq_in),
        .sync_out(dq_sync)
    );

    bbf_cycle u_cycle (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(start_q),
        .req(req_q),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .dq_in(dq_sync),
        .ctl(fl_ctl),
        .addr(fl_addr),
        .dq_out(fl_dq_out),
        .dq_oe(fl_dq_oe)
    );

    // ==========================================================
    // APB slave: zero wait, read data latched in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                pslverr <= !(paddr inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_RDATA, REG_STAT});
                unique case (paddr)
                    REG_CTRL: prdata <= {24'h0, lanes_q, op_q};
                    REG_ADDR: prdata <= {11'h0, addr_q};
                    REG_WDATA: prdata <= wdata_q;
                    REG_RDATA: prdata <= rdata_q;
                    REG_STAT: prdata <= {27'h0, susp_q, byp_q, refused_q, done_q, !idle};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // Software registers, writable only while idle
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            addr_q <= '0;
            wdata_q <= '0;
            lanes_q <= LANES_RST;
        end else if (wr_take && idle) begin
            if (paddr == REG_ADDR) begin
                addr_q <= pwdata[ADDR_W-1:0];
            end
            if (paddr == REG_WDATA) begin
                wdata_q <= pwdata;
            end
            if (paddr == REG_CTRL && op_new != OP_SUSPEND) begin
                lanes_q <= pwdata[CTRL_LANE_LSB +: 4];
            end
        end
    end

    // ==========================================================
    // Sticky flags; a new event beats a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (finish) begin
                done_q <= 1'b1;
            end else if (wr_take && paddr == REG_STAT && pwdata[STAT_DONE]) begin
                done_q <= 1'b0;
            end
            if (refuse) begin
                refused_q <= 1'b1;
            end else if (wr_take && paddr == REG_STAT && pwdata[STAT_REFUSED]) begin
                refused_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Device mode tracking
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            byp_q <= 1'b0;
            susp_q <= 1'b0;
        end else if (state_q == S_RST) begin
            // Device falls back to array read after its reset
            byp_q <= 1'b0;
            susp_q <= 1'b0;
        end else if (finish) begin
            if (op_q == OP_BYP_ENTER) begin
                byp_q <= 1'b1;
            end
            if (op_q == OP_BYP_EXIT) begin
                byp_q <= 1'b0;
            end
            if (op_q == OP_SUSPEND) begin
                susp_q <= 1'b1;
            end
            if (erase_run) begin
                susp_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Operation sequencer
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            op_q <= OP_READ;
            step_q <= 3'd0;
            start_q <= 1'b0;
            req_q <= '0;
            rdata_q <= '0;
            rst_cnt_q <= 8'h00;
            fl_reset_n <= 1'b1;
            pend_susp_q <= 1'b0;
            have_prev_q <= 1'b0;
            prev_q <= 4'h0;
        end else begin
            start_q <= 1'b0;
            unique case (state_q)
                S_IDLE: if (accept) begin
                    op_q <= op_new;
                    step_q <= 3'd0;
                    if (op_new == OP_HW_RESET) begin
                        state_q <= S_RST;
                        rst_cnt_q <= 8'(RP_CYC - 1);
                        fl_reset_n <= 1'b0;
                    end else begin
                        state_q <= S_CMD;
                        start_q <= 1'b1;
                        req_q <= cmd_step(op_new, 3'd0, byp_q, addr_q, wdata_q,
                                          pwdata[CTRL_LANE_LSB +: 4]);
                    end
                end
                S_CMD: if (cyc_done) begin
                    if (!last_step) begin
                        step_q <= step_q + 3'd1;
                        start_q <= 1'b1;
                        req_q <= cmd_step(op_q, step_q + 3'd1, byp_q, addr_q, wdata_q,
                                          lanes_q);
                    end else if (op_q inside {OP_PROG, OP_ERASE_SEC, OP_ERASE_ALL,
                                              OP_RESUME}) begin
                        state_q <= S_POLL;
                        have_prev_q <= 1'b0;
                        start_q <= 1'b1;
                        req_q <= cmd_step(OP_READ, 3'd0, byp_q, addr_q, wdata_q, lanes_q);
                    end else begin
                        state_q <= S_IDLE;
                        if (op_q == OP_READ) begin
                            rdata_q <= cyc_rdata;
                        end
                    end
                end
                S_POLL: begin
                    if (accept) begin
                        pend_susp_q <= 1'b1;
                    end
                    if (cyc_done) begin
                        if (pend_susp_q) begin
                            // Suspend goes out once the poll read is off the bus
                            pend_susp_q <= 1'b0;
                            op_q <= OP_SUSPEND;
                            step_q <= 3'd0;
                            state_q <= S_CMD;
                            start_q <= 1'b1;
                            req_q <= cmd_step(OP_SUSPEND, 3'd0, byp_q, addr_q, wdata_q,
                                              lanes_q);
                        end else if (poll_match) begin
                            // Toggle bit stopped: device back in array read
                            state_q <= S_IDLE;
                            // Suspend that lost the race to completion is dropped
                            pend_susp_q <= 1'b0;
                        end else begin
                            prev_q <= toggle_bits(cyc_rdata, lanes_q);
                            have_prev_q <= 1'b1;
                            start_q <= 1'b1;
                            req_q <= cmd_step(OP_READ, 3'd0, byp_q, addr_q, wdata_q,
                                              lanes_q);
                        end
                    end
                end
                S_RST: if (rst_cnt_q == 8'h00) begin
                    state_q <= S_REC;
                    rst_cnt_q <= 8'(RH_CYC - 1);
                    fl_reset_n <= 1'b1;
                end else begin
                    rst_cnt_q <= rst_cnt_q - 8'h01;
                end
                S_REC: if (rst_cnt_q == 8'h00) begin
                    state_q <= S_IDLE;
                end else begin
                    rst_cnt_q <= rst_cnt_q - 8'h01;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule : bbf_host_ctrl
`default_nettype wire

// ==== rtl/bbf_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module bbf_sync #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : bbf_sync
`default_nettype wire

// ==== tb/bbf_flash_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module bbf_flash_model import bbf_pkg::*; (
    // Device pins
    input wire bbf_ctl_t ctl,
    input wire logic [20:0] addr,
    input wire logic [31:0] dq,
    input wire logic reset_n,
    output logic [31:0] q
);
    // ========================================
    // Command latch and embedded operations
    logic [31:0] mem [logic [20:0]];
    logic [31:0] rd_q = 32'h0;
    logic [7:0] last_b = 8'h00;
    int busy = 0;
    localparam int PROT_SEC = 34; // Arbitrary protected sector
    localparam bit VCC_OK = 1'b1;
    wire we_all = &ctl.we_n;
    function automatic int sec(input logic [20:0] a);
        if (a[20:16] != 5'h00) return int'(a[20:16]) + 3;
        return a[15] ? 3 : a[14] ? (a[13] ? 2 : 1) : 0;
    endfunction : sec
    // Released bus shows the inverse of the last read
    assign q = ctl.oe_n ? ~rd_q : rd_q;
    always @(posedge we_all) begin
        if (reset_n && VCC_OK && busy > 0) begin
            if (dq[7:0] == CMD_SUSPEND) busy = 0;
        end else if (reset_n && VCC_OK) begin
            if (last_b == CMD_PROG && sec(addr) != PROT_SEC) mem[addr] = dq;
            if (last_b == CMD_PROG || dq[7:0] inside {CMD_SECTOR, CMD_CHIP}) busy = 3;
            // Erase needs the unlock prefix; the protected sector survives
            if (last_b == CMD_UNLOCK2 && dq[7:0] inside {CMD_SECTOR, CMD_CHIP})
                foreach (mem[k]) if (sec(k) != PROT_SEC && (dq[7:0] == CMD_CHIP
                    || sec(k) == sec(addr))) mem[k] = '1;
            last_b = dq[7:0];
        end
    end
    // Sleep or standby never alter what a read returns
    always @(negedge ctl.oe_n) begin
        if (busy > 0) begin
            busy = busy - 1;
            rd_q = {4{1'h0, busy[0], 6'h00}};
        end else rd_q = mem.exists(addr) ? mem[addr] : 32'hffffffff;
    end
    always @(negedge reset_n) busy = 0;
endmodule : bbf_flash_model
`default_nettype wire

// ==== tb/bbf_host_ctrl_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module bbf_chk import bbf_pkg::*; (
    // Clock, reset and flash pins
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic fl_reset_n,
    input wire bbf_ctl_t fl_ctl,
    input wire logic [20:0] fl_addr,
    input wire logic [31:0] fl_dq_out,
    input wire logic [3:0] fl_dq_oe
);
    // ========================================
    // Pin protocol
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire we_lo = !(&fl_ctl.we_n);
    sequence s_pulse;
        we_lo[*7] ##1 !we_lo;
    endsequence
    a_we_pulse: assert property ($rose(we_lo) |-> s_pulse) else $error("strobe width");
    a_we_setup: assert property ($rose(we_lo) |-> $past(fl_ctl.cs_n, 2) == fl_ctl.cs_n)
        else $error("select setup");
    a_we_oe: assert property (we_lo |-> fl_ctl.oe_n && (~fl_ctl.we_n & fl_ctl.cs_n) == 4'h0)
        else $error("write levels");
    a_rd_no_we: assert property (!fl_ctl.oe_n |-> &fl_ctl.we_n) else $error("read levels");
    a_lane_drive: assert property ((fl_dq_oe & fl_ctl.cs_n) == 4'h0) else $error("lane drive");
    a_wr_stable: assert property (we_lo && $past(we_lo) |-> $stable(fl_addr) && $stable(fl_dq_out))
        else $error("write not stable");
    a_rst_pulse: assert property ($fell(fl_reset_n) |-> ##99 !fl_reset_n ##1 fl_reset_n)
        else $error("reset pulse");
    a_rst_idle: assert property (!$past(nrst) |-> fl_ctl == CTL_IDLE && fl_dq_oe == 4'h0
        && fl_reset_n) else $error("not idle after reset");
endmodule : bbf_chk
bind bbf_host_ctrl bbf_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .fl_reset_n(fl_reset_n),
    .fl_ctl(fl_ctl), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb import bbf_pkg::*;;
    localparam bbf_op_t OPS[7] = '{OP_WRITE, OP_BYP_ENTER, OP_PROG, OP_BYP_EXIT, OP_ERASE_SEC,
        OP_ERASE_ALL, OP_HW_RESET};
    localparam logic [31:0] STS[7] = '{32'h2, 32'ha, 32'ha, 32'h2, 32'h2, 32'h2, 32'h2};
    logic sys_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, want = 1'h0;
    logic pready, pslverr, fl_reset_n;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, dq_w, fl_dq_out, rd;
    logic [15:0] seed = 16'h8461;
    logic [20:0] fl_addr;
    logic [3:0] fl_dq_oe;
    bbf_ctl_t fl_ctl;
    logic [31:0] exq[$];
    int error_cnt = 0, n_checks = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    always_comb for (int i = 0; i < 32; i++) dq_w[i] = fl_dq_oe[i/8] ? fl_dq_out[i] : q[i];
    bbf_host_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fl_ctl(fl_ctl), .fl_addr(fl_addr), .fl_dq_in(dq_w),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_reset_n(fl_reset_n));
    bbf_flash_model u_flash (.ctl(fl_ctl), .addr(fl_addr), .dq(dq_w), .reset_n(fl_reset_n), .q(q));
    // ========================================
    // Bus tasks and checking
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0; penable <= 1'h0; want <= 1'h0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        exq.push_back(e);
        want <= 1'h1;
        apb(1'h0, a, 32'h0);
    endtask : rdx
    task automatic wait_idle;
        do apb(1'h0, REG_STAT, 32'h0); while (rd[STAT_BUSY] !== 1'h0);
    endtask : wait_idle
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // Read results come back in the order they were asked for
    always @(posedge sys_clk) if (want && psel && penable && pready) chk("rdata", prdata, exq.pop_front());
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
    // ========================================
    // Scenarios
    initial begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'h1;
        @(posedge sys_clk);
        rdx(REG_STAT, 32'h0);
        rdx(8'h40, 32'h0);
        chk("pslverr", {31'h0, pslverr}, 32'h1);
        seed = lfsr(seed);
        apb(1'h1, REG_ADDR, {16'h0000, seed});
        apb(1'h1, REG_WDATA, {seed, ~seed});
        apb(1'h1, REG_CTRL, 32'hf2);
        apb(1'h1, REG_CTRL, 32'hf0);
        wait_idle();
        rdx(REG_STAT, 32'h6);
        apb(1'h1, REG_STAT, 32'h6);
        apb(1'h1, REG_CTRL, 32'hf0);
        wait_idle();
        rdx(REG_RDATA, {seed, ~seed});
        $display("test program and read done");
        foreach (OPS[i]) begin
            apb(1'h1, REG_CTRL, {24'h0, 4'h1, OPS[i]});
            wait_idle();
            rdx(REG_STAT, STS[i]);
            apb(1'h1, REG_STAT, 32'h6);
        end
        $display("test operation table done");
        apb(1'h1, REG_CTRL, {24'h0, 4'h1, OP_ERASE_SEC});
        @(negedge fl_ctl.oe_n);
        apb(1'h1, REG_CTRL, {24'h0, 4'h1, OP_SUSPEND});
        wait_idle();
        rdx(REG_STAT, 32'h12);
        apb(1'h1, REG_STAT, 32'h6);
        apb(1'h1, REG_CTRL, {24'h0, 4'h1, OP_RESUME});
        wait_idle();
        rdx(REG_STAT, 32'h2);
        apb(1'h1, REG_CTRL, {24'h0, 4'h1, OP_READ});
        wait_idle();
        rdx(REG_RDATA, 32'hffffffff);
        $display("test suspend and erase done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
